//--- inc/srs_map.svh
// Constants for the serial register access slave: address, timing counts.
// Assumes a 10 MHz core clock.
`ifndef SRS_MAP_SVH
`define SRS_MAP_SVH
`define SRS_SLAVE_ADDR   7'h28
`define SRS_CLK_HZ       10_000_000
`define SRS_TIMEOUT_MS   30
`define SRS_TIMEOUT_CYC  ((`SRS_TIMEOUT_MS * `SRS_CLK_HZ) / 1000)
`endif

//--- inc/srs_pkg.sv
// Types shared by the serial register access slave.
// Assumes nothing of its surroundings.
package srs_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } srs_wr_t;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK
   } srs_state_t;
endpackage

//--- verilog/srs_slave.sv
// Serial register access slave: byte, pointer and block transfers to an 8-bit
// register space. Assumes the register space answers reads combinationally
// from rd_addr and takes writes presented through a two-entry buffer.
//
// Behaviour
// - Answer only slave address 0101000; direction bit selects write or read.
// - Write byte: index then data, each acknowledged, data stored at index.
// - Read byte: index write, repeated start, one byte returned, host nacks.
// - Index alone followed by stop only loads the register pointer.
// - Read without index returns byte at pointer without advancing it.
// - Pointer-only set is still carried out while deep sleep is requested.
// - Read at pointer may be skipped while deep sleep is requested.
// - Block write stores each byte at pointer, acks, increments with wrap; a byte arriving with the write buffer full is nacked and dropped.
// - Block read sends successive bytes, incrementing pointer with wrap.
// - A stop resets the slave state and readies a new transaction.
// - Optional 30 ms low clock timeout resets the slave; off after reset.
`timescale 1ns/100ps
`include "srs_map.svh"
module srs_slave #(
   parameter int TIMEOUT_CYC = `SRS_TIMEOUT_CYC
) (
   input  wire logic           clk,
   input  wire logic           rst,
   input  wire logic           serial_clock_pin,
   input  wire logic           serial_data_pin_i,
   output logic                serial_data_pin_o,
   output logic                serial_data_pin_oe,
   input  wire logic           deep_sleep_request_bit,
   input  wire logic           timeout_enable,
   output logic [7:0]          rd_addr,
   input  wire logic [7:0]     rd_data,
   output logic                wr_valid,
   input  wire logic           wr_ready,
   output srs_pkg::srs_wr_t    wr_word,
   output logic                busy
);
   // ==========================================================================
   // Pin synchronisers and condition detection
   // ==========================================================================
   logic [1:0] scl_s_r;
   logic [1:0] sda_s_r;
   logic       scl_d_r;
   logic       sda_d_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_s_r <= 2'h3;
         sda_s_r <= 2'h3;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_s_r <= {scl_s_r[0], serial_clock_pin};
         sda_s_r <= {sda_s_r[0], serial_data_pin_i};
         scl_d_r <= scl_s_r[1];
         sda_d_r <= sda_s_r[1];
      end
   end
   wire scl      = scl_s_r[1];
   wire sda      = sda_s_r[1];
   wire scl_rise = scl & ~scl_d_r;
   wire scl_fall = ~scl & scl_d_r;
   wire start_c  = scl & scl_d_r & ~sda & sda_d_r;
   wire stop_c   = scl & scl_d_r & sda & ~sda_d_r;

   // ==========================================================================
   // Bus timeout
   // ==========================================================================
   localparam int TW = $clog2(TIMEOUT_CYC + 1);
   logic [TW-1:0] to_cnt_r;
   wire           to_hit = (to_cnt_r == TW'(TIMEOUT_CYC));
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         to_cnt_r <= '0;
      end else if (!timeout_enable || scl || to_hit) begin
         to_cnt_r <= '0;
      end else begin
         to_cnt_r <= to_cnt_r + TW'(1);
      end
   end

   // ==========================================================================
   // Protocol engine
   // ==========================================================================
   srs_pkg::srs_state_t st_r, st_nxt;
   logic [7:0] sh_r;
   logic [3:0] bit_r;
   logic [7:0] ptr_r;
   logic       idx_seen_r;
   logic       rd_idx_r;
   logic       sda_oe_r;
   logic       mack_r;
   logic       push;
   logic [1:0] cnt_r;
   logic       buf_ready;

   wire       byte_done = scl_fall & (bit_r == 4'h8);
   wire [7:0] rx_byte   = sh_r;
   wire       addr_hit  = (rx_byte[7:1] == `SRS_SLAVE_ADDR);
   wire       rx_read   = rx_byte[0];
   wire       shift_in  = (st_r == srs_pkg::ST_ADDR) || (st_r == srs_pkg::ST_RX);
   wire       reset_c   = stop_c | to_hit;
   // Address-free reads are skipped in deep sleep.
   wire       rd_allowed = rd_idx_r | ~deep_sleep_request_bit;

   assign rd_addr            = ptr_r;
   assign serial_data_pin_o  = 1'b0;
   assign serial_data_pin_oe = sda_oe_r;
   assign busy               = (st_r != srs_pkg::ST_IDLE);

   always_comb begin
      st_nxt = st_r;
      push   = 1'b0;
      case (st_r)
         srs_pkg::ST_IDLE:     st_nxt = st_r;
         srs_pkg::ST_ADDR:     if (byte_done) begin
            st_nxt = (addr_hit && (!rx_read || rd_allowed)) ? srs_pkg::ST_ADDR_ACK
                                                              : srs_pkg::ST_IDLE;
         end
         srs_pkg::ST_ADDR_ACK: if (scl_fall) begin
            st_nxt = sh_r[0] ? srs_pkg::ST_TX : srs_pkg::ST_RX;
         end
         srs_pkg::ST_RX:       if (byte_done) begin
            // A full buffer means no room: the byte is not acked.
            st_nxt = (!idx_seen_r || buf_ready) ? srs_pkg::ST_RX_ACK : srs_pkg::ST_IDLE;
            push   = idx_seen_r & buf_ready;
         end
         srs_pkg::ST_RX_ACK:   if (scl_fall) begin
            st_nxt = srs_pkg::ST_RX;
         end
         srs_pkg::ST_TX:       if (byte_done) begin
            st_nxt = srs_pkg::ST_TX_ACK;
         end
         srs_pkg::ST_TX_ACK:   if (scl_fall) begin
            st_nxt = mack_r ? srs_pkg::ST_TX : srs_pkg::ST_IDLE;
         end
         default:              st_nxt = srs_pkg::ST_IDLE;
      endcase
      if (start_c) begin
         st_nxt = srs_pkg::ST_ADDR;
      end else if (reset_c) begin
         st_nxt = srs_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= srs_pkg::ST_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Bit shifter: samples on rising clock in receive states; in transmit it
   // counts rising clocks and shifts on falling ones.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sh_r  <= 8'h00;
         bit_r <= 4'h0;
      end else if (start_c || (scl_fall && (st_r == srs_pkg::ST_ADDR_ACK
                               || st_r == srs_pkg::ST_RX_ACK || st_r == srs_pkg::ST_TX_ACK))) begin
         bit_r <= 4'h0;
         if (st_r == srs_pkg::ST_ADDR_ACK && sh_r[0]) begin
            sh_r <= rd_data;
         end else if (st_r == srs_pkg::ST_TX_ACK) begin
            sh_r <= rd_data;
         end
      end else if (byte_done) begin
         bit_r <= 4'h0;
      end else if (scl_rise && shift_in) begin
         sh_r  <= {sh_r[6:0], sda};
         bit_r <= bit_r + 4'h1;
      end else if (scl_rise && st_r == srs_pkg::ST_TX) begin
         bit_r <= bit_r + 4'h1;
      end else if (scl_fall && st_r == srs_pkg::ST_TX) begin
         sh_r  <= {sh_r[6:0], 1'b1};
      end
   end

   // Drives data low for acks and for zero bits of a transmitted byte.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sda_oe_r <= 1'b0;
      end else if (st_nxt == srs_pkg::ST_ADDR_ACK || st_nxt == srs_pkg::ST_RX_ACK) begin
         sda_oe_r <= 1'b1;
      end else if (st_nxt == srs_pkg::ST_TX) begin
         sda_oe_r <= (st_r == srs_pkg::ST_TX) ? (scl_fall ? ~sh_r[6] : sda_oe_r)
                                              : ~rd_data[7];
      end else begin
         sda_oe_r <= 1'b0;
      end
   end

   // Pointer, index flag and master acknowledge capture.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ptr_r      <= 8'h00;
         idx_seen_r <= 1'b0;
         rd_idx_r   <= 1'b0;
         mack_r     <= 1'b0;
      end else begin
         if (st_r == srs_pkg::ST_TX_ACK && scl_rise) begin
            mack_r <= ~sda;
         end
         if (stop_c || to_hit) begin
            rd_idx_r <= 1'b0;
         end else if (st_r == srs_pkg::ST_ADDR && byte_done && !rx_read) begin
            rd_idx_r   <= 1'b0;
            idx_seen_r <= 1'b0;
         end
         if (st_r == srs_pkg::ST_RX && byte_done && !idx_seen_r) begin
            // Pointer-only sets are still carried out in deep sleep.
            ptr_r      <= rx_byte;
            idx_seen_r <= 1'b1;
            rd_idx_r   <= 1'b1;
         end else if (push) begin
            ptr_r <= ptr_r + 8'h01;
         end else if (st_r == srs_pkg::ST_TX_ACK && scl_rise && (!sda || rd_idx_r)) begin
            // Advancing at the acknowledge sample lets the next byte load from the new pointer.
            ptr_r <= ptr_r + 8'h01;
         end
      end
   end

   // ==========================================================================
   // Two-entry write buffer
   // ==========================================================================
   srs_pkg::srs_wr_t buf_r [2];
   logic             rp_r;
   logic             wp_r;
   wire              pop = wr_valid & wr_ready;
   assign wr_valid  = (cnt_r != 2'h0);
   assign wr_word   = buf_r[rp_r];
   assign buf_ready = (cnt_r != 2'h2);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r    <= 2'h0;
         rp_r     <= 1'b0;
         wp_r     <= 1'b0;
         buf_r[0] <= '0;
         buf_r[1] <= '0;
      end else begin
         if (push && buf_ready) begin
            buf_r[wp_r] <= '{addr: ptr_r, data: rx_byte};
            wp_r        <= ~wp_r;
         end
         if (pop) begin
            rp_r <= ~rp_r;
         end
         cnt_r <= cnt_r + {1'b0, push & buf_ready} - {1'b0, pop};
      end
   end

   // ==========================================================================
   // Assertions
   // ==========================================================================
   a_stop_resets: assert property (@(posedge clk) disable iff (rst)
      stop_c && !start_c |=> st_r == srs_pkg::ST_IDLE)
      else $error("stop did not reset slave");
   a_timeout_off: assert property (@(posedge clk) disable iff (rst)
      !timeout_enable |=> to_cnt_r == '0)
      else $error("timeout counted while disabled");
   a_addr_match: assert property (@(posedge clk) disable iff (rst)
      st_r == srs_pkg::ST_ADDR && byte_done && !addr_hit && !start_c && !reset_c
      |=> st_r == srs_pkg::ST_IDLE)
      else $error("foreign address accepted");
   a_write_inc: assert property (@(posedge clk) disable iff (rst)
      push |=> ptr_r == $past(ptr_r) + 8'h01)
      else $error("pointer not advanced on write");
   a_ack_drive: assert property (@(posedge clk) disable iff (rst)
      st_r == srs_pkg::ST_RX_ACK ##1 st_r == srs_pkg::ST_RX_ACK |-> serial_data_pin_oe)
      else $error("ack not driven");
   a_idle_release: assert property (@(posedge clk) disable iff (rst)
      st_r == srs_pkg::ST_IDLE ##1 st_r == srs_pkg::ST_IDLE |-> !serial_data_pin_oe)
      else $error("data driven while idle");
   a_sleep_recv: assert property (@(posedge clk) disable iff (rst)
      st_r == srs_pkg::ST_ADDR && byte_done && addr_hit && rx_read && !rd_allowed
      && !start_c && !reset_c |=> st_r == srs_pkg::ST_IDLE)
      else $error("address-free read in deep sleep");
   a_write_push: assert property (@(posedge clk) disable iff (rst)
      push |-> idx_seen_r && st_r == srs_pkg::ST_RX)
      else $error("write outside data phase");
   sequence s_free_nack;
      st_r == srs_pkg::ST_TX_ACK && scl_rise && sda && !rd_idx_r;
   endsequence
   sequence s_idx_sent;
      st_r == srs_pkg::ST_TX_ACK && scl_rise && rd_idx_r;
   endsequence
   a_free_hold: assert property (@(posedge clk) disable iff (rst)
      s_free_nack |=> ptr_r == $past(ptr_r))
      else $error("pointer moved on address-free read");
   a_read_inc: assert property (@(posedge clk) disable iff (rst)
      s_idx_sent |=> ptr_r == $past(ptr_r) + 8'h01)
      else $error("pointer not advanced on read");
endmodule

//--- verification/srs_host_model.sv
// Host bus master model that drives the serial clock and pulls the data wire.
// Assumes a pull-up on the data wire. The clock idles high between frames.
`timescale 1ns/100ps
module srs_host_model (
   scl,
   sda_pull,
   sda
);
   output logic      scl;
   output logic      sda_pull;
   input  wire logic sda;
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // Data moves 150 ns after the falling clock so it cannot pass for a start or a stop.
   // Every pin change lands 25 ns off a core clock edge, away from the sampling instant.
   task automatic bit_io(input logic b, output logic s);
      #125 sda_pull = ~b;
      #300 scl = 1'b1;
      #350 s = sda;
      scl = 1'b0;
      #25;
   endtask
   task automatic start();
      #125 sda_pull = 1'b0;
      #300 scl = 1'b1;
      #300 sda_pull = 1'b1;
      #250 scl = 1'b0;
      #25;
   endtask
   task automatic stop();
      #125 sda_pull = 1'b1;
      #300 scl = 1'b1;
      #300 sda_pull = 1'b0;
      #375;
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   task automatic rbyte(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         d[i] = s;
      end
      bit_io(~ack, s);
   endtask
endmodule

//--- verification/srs_slave_tb_top.sv
// Testbench for the serial register access slave with a host model on the bus.
// Assumes the host model file and the design package are compiled first.
`timescale 1ns/100ps
module srs_slave_tb_top;
   logic             clk = 1'b0;
   logic             rst = 1'b1;
   logic             sleep_req = 1'b0;
   logic             to_en = 1'b0;
   logic             wr_ready = 1'b1;
   logic [7:0]       regs [256];
   logic [7:0]       rd_addr;
   logic             wr_valid;
   logic             dev_oe;
   logic             scl;
   logic             host_pull;
   logic             busy;
   srs_pkg::srs_wr_t wr_word;
   wire              sda = ~(dev_oe | host_pull);
   int               fails = 0;
   int               check_count = 0;
   always #50 clk = ~clk;
   srs_slave #(.TIMEOUT_CYC(50)) srs_slave_inst (
      .clk(clk), .rst(rst), .serial_clock_pin(scl), .serial_data_pin_i(sda),
      .serial_data_pin_o(), .serial_data_pin_oe(dev_oe), .deep_sleep_request_bit(sleep_req),
      .timeout_enable(to_en), .rd_addr(rd_addr), .rd_data(regs[rd_addr]),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word), .busy(busy)
   );
   srs_host_model srs_host_model_inst (.scl(scl), .sda_pull(host_pull), .sda(sda));
   always @(posedge clk) begin
      if (wr_valid && wr_ready) begin
         regs[wr_word.addr] <= wr_word.data;
      end
   end
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wb(input logic [7:0] d, input logic exp);
      logic a;
      srs_host_model_inst.wbyte(d, a);
      chk("ack", {7'h00, exp}, {7'h00, a});
   endtask
   task automatic rb(input logic ack, input logic [7:0] exp);
      logic [7:0] d;
      srs_host_model_inst.rbyte(ack, d);
      chk("data", exp, d);
   endtask
   task automatic busy_is(input logic exp);
      @(negedge clk);
      chk("busy", {7'h00, exp}, {7'h00, busy});
   endtask
   task automatic rd_at(input logic [7:0] idx, input logic [7:0] exp);
      srs_host_model_inst.start();
      wb(8'h50, 1'b1);
      wb(idx, 1'b1);
      srs_host_model_inst.start();
      wb(8'h51, 1'b1);
      rb(1'b0, exp);
      srs_host_model_inst.stop();
   endtask
   task automatic t_byte();
      srs_host_model_inst.start();
      wb(8'h50, 1'b1);
      wb(8'h10, 1'b1);
      wb(8'hA5, 1'b1);
      srs_host_model_inst.stop();
      repeat (5) @(posedge clk);
      busy_is(1'b0);
      rd_at(8'h10, 8'hA5);
      srs_host_model_inst.start();
      wb(8'h52, 1'b0);
      srs_host_model_inst.stop();
      $display("end t_byte");
   endtask
   task automatic t_block();
      @(posedge clk) wr_ready <= 1'b0;
      srs_host_model_inst.start();
      wb(8'h50, 1'b1);
      wb(8'hFE, 1'b1);
      wb(8'h11, 1'b1);
      wb(8'h22, 1'b1);
      @(posedge clk) wr_ready <= 1'b1;
      wb(8'h33, 1'b1);
      srs_host_model_inst.stop();
      srs_host_model_inst.start();
      wb(8'h50, 1'b1);
      wb(8'hFE, 1'b1);
      srs_host_model_inst.start();
      wb(8'h51, 1'b1);
      rb(1'b1, 8'h11);
      rb(1'b1, 8'h22);
      rb(1'b0, 8'h33);
      srs_host_model_inst.stop();
      $display("end t_block");
   endtask
   task automatic t_pointer();
      srs_host_model_inst.start();
      wb(8'h50, 1'b1);
      wb(8'h20, 1'b1);
      srs_host_model_inst.stop();
      repeat (2) begin
         srs_host_model_inst.start();
         wb(8'h51, 1'b1);
         rb(1'b0, 8'h1C);
         srs_host_model_inst.stop();
      end
      $display("end t_pointer");
   endtask
   task automatic t_sleep();
      @(posedge clk) sleep_req <= 1'b1;
      srs_host_model_inst.start();
      wb(8'h51, 1'b0);
      busy_is(1'b0);
      srs_host_model_inst.stop();
      rd_at(8'h10, 8'hA5);
      @(posedge clk) sleep_req <= 1'b0;
      $display("end t_sleep");
   endtask
   task automatic t_timeout();
      srs_host_model_inst.start();
      wb(8'h50, 1'b1);
      repeat (70) @(posedge clk);
      busy_is(1'b1);
      @(posedge clk) to_en <= 1'b1;
      repeat (70) @(posedge clk);
      busy_is(1'b0);
      srs_host_model_inst.stop();
      @(posedge clk) to_en <= 1'b0;
      $display("end t_timeout");
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      for (int i = 0; i < 256; i++) begin
         regs[i] = i[7:0] ^ 8'h3C;
      end
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      t_byte();
      t_block();
      t_pointer();
      t_sleep();
      t_timeout();
      stop_test();
   end
   initial begin
      repeat (40000) @(posedge clk);
      fails++;
      $display("BAD watchdog expected finish seen hang");
      stop_test();
   end
endmodule
